// ==== design/rfo_consts.svh ====
/*
 * Constants for the rail force-on and output level register block.
 * Assumes the serial-bus front end presents decoded byte accesses.
 */
`ifndef RFO_CONSTS_SVH
`define RFO_CONSTS_SVH

`define RFO_REG_OFFSET      8'ha1
`define RFO_RESET_VALUE     8'h00
`define RFO_BIT_PIN4_LEVEL  7
`define RFO_BIT_PIN3_LEVEL  6
`define RFO_BIT_PIN2_LEVEL  5
`define RFO_BIT_PIN1_LEVEL  4
`define RFO_BIT_TERM_FORCE  3
`define RFO_BIT_SHARED_FORCE 2
`define RFO_BIT_LOAD_SWITCH_B1_FORCE  1
`define RFO_BIT_LDO3_FORCE  0

`endif

// ==== design/rfo_pkg.sv ====
/*
 * Types for the rail force-on and output level register block.
 * Assumes rfo_consts.svh is available on the include path.
 */
`default_nettype none

package rfo_pkg;

    // Per-rail control: index 3 term, 2 shared, 1 switch b1, 0 ldo3
    typedef struct packed {
        logic [3:0] force_on;
        logic [3:0] disable_n;
        logic [3:0] seq_enable;
    } rfo_rail_ctl_t;

    // Factory configuration of one general output pin
    typedef struct packed {
        logic bus_controlled;
        logic push_pull;
    } rfo_pin_cfg_t;

endpackage : rfo_pkg

`default_nettype wire

// ==== design/rfo_rail_force_on.sv ====
/*
 * Register at A1h: output pin levels and rail force-on overrides.
 * Assumes a serial-bus front end on clk delivering one-cycle write and
 * read strobes with a byte address, and factory straps held stable.
 * Pin and sequencer inputs from other domains are synchronised here.
 */
`include "rfo_consts.svh"
`default_nettype none

// Functional notes
// - Eight-bit read/write register at offset A1h
// - Bit 7 sets pin 4 open-drain level
// - Bits 6..4 set pins 3..1 levels
// - Unused level bit: pin follows power-good
// - Bit 3 low: termination follows pins/sequencing
// - Bit 3 high: termination forced on unless disabled
// - Bit 2 forces on selected shared rail
// - Bit 1 forces load switch B1 on
// - Bit 0 forces auxiliary LDO 3 on
// - Disable bit low always turns rail off
module rfo_rail_force_on #(
    parameter int RAILS = 4,
    parameter int PINS  = 4
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    input  wire logic [7:0]            addr,
    input  wire logic [7:0]            wdata,
    output var  logic [7:0]            rdata_q,
    output var  logic                  rvalid_q,
    input  wire logic [RAILS-1:0]      rail_disable_n,
    input  wire logic [RAILS-1:0]      ctl_seq_enable,
    input  wire logic                  shared_is_switch_b2,
    input  wire rfo_pkg::rfo_pin_cfg_t [PINS-1:0] pin_cfg,
    input  wire logic [PINS-1:0]       pin_power_good,
    output var  logic [RAILS-1:0]      rail_on_q,
    output var  logic                  switch_b2_on_q,
    output var  logic                  aux_ldo1_on_q,
    output var  logic [PINS-1:0]       pin_out_q,
    output var  logic [PINS-1:0]       pin_oe_q
);

    logic [7:0]            reg_q;
    logic [RAILS-1:0]      seq_meta_q;
    logic [RAILS-1:0]      seq_sync_q;
    logic [PINS-1:0]       pg_meta_q;
    logic [PINS-1:0]       pg_sync_q;
    rfo_pkg::rfo_rail_ctl_t ctl;
    logic [RAILS-1:0]      rail_on_d;
    logic [PINS-1:0]       pin_level;
    logic                  hit;
    logic [7:0]            rd_word;
    logic                  term_ldo_force_on;
    logic                  shared_rail_force_on;
    logic                  switch_b1_force_on;
    logic                  aux_ldo3_force_on;
    logic                  output_pin4_level;
    logic                  output_pin3_level;
    logic                  output_pin2_level;
    logic                  output_pin1_level;
    logic                  switch_b2_on_d;
    logic                  aux_ldo1_on_d;
    logic [PINS-1:0]       pin_out_d;
    logic [PINS-1:0]       pin_oe_d;

    assign hit = (addr == `RFO_REG_OFFSET);

    // Register storage, all bits writable
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            reg_q <= `RFO_RESET_VALUE;
        else if (wr_en && hit)
            reg_q <= wdata;
    end

    // Unmapped addresses read as zero
    always_comb
    begin
        rd_word = 8'h00;
        if (hit)
            rd_word = reg_q;
    end

    // Read path; data holds until the next read
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= rd_en;
            if (rd_en)
                rdata_q <= rd_word;
        end
    end

    // Sequencer enables and power-good come from analogue/pin side
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            seq_meta_q <= '0;
            seq_sync_q <= '0;
            pg_meta_q  <= '0;
            pg_sync_q  <= '0;
        end
        else
        begin
            seq_meta_q <= ctl_seq_enable;
            seq_sync_q <= seq_meta_q;
            pg_meta_q  <= pin_power_good;
            pg_sync_q  <= pg_meta_q;
        end
    end

    // Named fields of the register
    assign output_pin4_level    = reg_q[`RFO_BIT_PIN4_LEVEL];
    assign output_pin3_level    = reg_q[`RFO_BIT_PIN3_LEVEL];
    assign output_pin2_level    = reg_q[`RFO_BIT_PIN2_LEVEL];
    assign output_pin1_level    = reg_q[`RFO_BIT_PIN1_LEVEL];
    assign term_ldo_force_on    = reg_q[`RFO_BIT_TERM_FORCE];
    assign shared_rail_force_on = reg_q[`RFO_BIT_SHARED_FORCE];
    assign switch_b1_force_on   = reg_q[`RFO_BIT_LOAD_SWITCH_B1_FORCE];
    assign aux_ldo3_force_on    = reg_q[`RFO_BIT_LDO3_FORCE];

    assign ctl.force_on   = {term_ldo_force_on, shared_rail_force_on,
                             switch_b1_force_on, aux_ldo3_force_on};
    assign ctl.disable_n  = rail_disable_n;
    assign ctl.seq_enable = seq_sync_q;
    assign pin_level      = {output_pin4_level, output_pin3_level,
                             output_pin2_level, output_pin1_level};

    // Disable gates last, over force and sequencing alike
    genvar i;
    generate
        for (i = 0; i < RAILS; i++)
        begin : g_rail
            logic en;
            always_comb
            begin
                en = ctl.seq_enable[i];
                if (ctl.force_on[i])
                    en = 1'b1;
                if (!ctl.disable_n[i])
                    en = 1'b0;
            end
            assign rail_on_d[i] = en;
        end
    endgenerate

    // Shared force-on reaches exactly one of two rails, by strap
    always_comb
    begin
        switch_b2_on_d = 1'b0;
        aux_ldo1_on_d  = 1'b0;
        if (shared_is_switch_b2)
            switch_b2_on_d = rail_on_d[`RFO_BIT_SHARED_FORCE];
        else
            aux_ldo1_on_d  = rail_on_d[`RFO_BIT_SHARED_FORCE];
    end

    // Registered so no enable glitches while the strap settles
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rail_on_q      <= '0;
            switch_b2_on_q <= 1'b0;
            aux_ldo1_on_q  <= 1'b0;
        end
        else
        begin
            rail_on_q      <= rail_on_d;
            switch_b2_on_q <= switch_b2_on_d;
            aux_ldo1_on_q  <= aux_ldo1_on_d;
        end
    end

    // Pin 4 has no push-pull option: open-drain only
    generate
        for (i = 0; i < PINS; i++)
        begin : g_pin
            logic lvl;
            logic pp;
            always_comb
            begin
                // Unconfigured pins fall back to their power-good tree
                if (pin_cfg[i].bus_controlled)
                    lvl = pin_level[i];
                else
                    lvl = pg_sync_q[i];
                pp = pin_cfg[i].push_pull && (i != PINS - 1);
            end
            // Open-drain only pulls low; the pull-up makes the high
            assign pin_out_d[i] = lvl;
            assign pin_oe_d[i]  = pp ? 1'b1 : !lvl;
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pin_oe_d;
        end
    end

endmodule // rfo_rail_force_on

`default_nettype wire

// ==== verif/rfo_rail_force_on_assertions.sv ====
/* Port checker; assumes a bind onto rfo_rail_force_on. */
`default_nettype none
module rfo_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic       rvalid_q,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata_q,
    input wire logic [3:0] rail_disable_n,
    input wire logic [3:0] ctl_seq_enable,
    input wire logic [3:0] rail_on_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire a1 = addr == 8'ha1;
    property p_rv; rd_en |=> rvalid_q; endproperty
    a_rv: assert property (p_rv) else $error("late");
    property p_nv; !rd_en |=> !rvalid_q; endproperty
    a_nv: assert property (p_nv) else $error("stray");
    property p_bad; rd_en && !a1 |=> rdata_q == 8'h00; endproperty
    a_bad: assert property (p_bad) else $error("bad");
    property p_hold; !rvalid_q |-> $stable(rdata_q); endproperty
    a_hold: assert property (p_hold) else $error("moved");
    property p_rw; wr_en && a1 ##1 !wr_en ##1 rd_en && a1 && !wr_en
        |=> rdata_q == $past(wdata, 3); endproperty
    a_rw: assert property (p_rw) else $error("lost");
    property p_dis; 1 |=> !(rail_on_q & ~$past(rail_disable_n)); endproperty
    a_dis: assert property (p_dis) else $error("on");
    property p_on; wr_en && a1 && wdata[3] ##1 !wr_en
        |=> rail_on_q[3] == $past(rail_disable_n[3]); endproperty
    a_on: assert property (p_on) else $error("off");
    property p_sq; wr_en && a1 && !wdata[3] ##1
        (!wr_en && !ctl_seq_enable[3]) [*4] |=> !rail_on_q[3]; endproperty
    a_sq: assert property (p_sq) else $error("idle");
    cover property (rvalid_q);
    cover property (rail_on_q[3]);
    cover property (wr_en && a1);
endmodule // rfo_chk
bind rfo_rail_force_on rfo_chk i_chk (
    .clk            (clk),
    .nrst           (nrst),
    .wr_en          (wr_en),
    .rd_en          (rd_en),
    .rvalid_q       (rvalid_q),
    .addr           (addr),
    .wdata          (wdata),
    .rdata_q        (rdata_q),
    .rail_disable_n (rail_disable_n),
    .ctl_seq_enable (ctl_seq_enable),
    .rail_on_q      (rail_on_q)
);
`default_nettype wire

// ==== verif/rfo_host.sv ====
/* Host model; assumes strobes sampled on the rising clk. */
`default_nettype none
module rfo_host (
    input  wire logic       clk,
    output var  logic       wr_en = 1'h0,
    output var  logic       rd_en = 1'h0,
    output var  logic [7:0] addr  = 8'h00,
    output var  logic [7:0] wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle edge after each access keeps strobes single pulses
    task automatic go(input logic w, input logic [7:0] a, d);
        @(posedge clk) #1;
        {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
        @(posedge clk) #1;
        {wr_en, rd_en} = 2'h0;
    endtask
endmodule // rfo_host
`default_nettype wire

// ==== verif/rfo_rail_force_on_tb.sv ====
/* Bench for rfo_rail_force_on; needs rfo_host and the checker. */
`default_nettype none
module rfo_rail_force_on_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, nrst = 1'h0, shared_is_switch_b2 = 1'h1;
    logic wr_en, rd_en, rvalid_q, switch_b2_on_q, aux_ldo1_on_q;
    logic [7:0] addr, wdata, rdata_q;
    logic [3:0] rail_disable_n = 4'hf, ctl_seq_enable = 4'h0;
    logic [3:0] pin_power_good = 4'h1, rail_on_q, pin_out_q, pin_oe_q;
    // Pin4 open-drain, pin3 push-pull, pin2 open-drain, pin1 unused
    rfo_pkg::rfo_pin_cfg_t [3:0] pin_cfg = 8'hb8;
    int n_fail = 0, tests_run = 0, cyc = 0;
    rfo_rail_force_on i_dut (
        .clk                 (clk),
        .nrst                (nrst),
        .wr_en               (wr_en),
        .rd_en               (rd_en),
        .addr                (addr),
        .wdata               (wdata),
        .rdata_q             (rdata_q),
        .rvalid_q            (rvalid_q),
        .rail_disable_n      (rail_disable_n),
        .ctl_seq_enable      (ctl_seq_enable),
        .shared_is_switch_b2 (shared_is_switch_b2),
        .pin_cfg             (pin_cfg),
        .pin_power_good      (pin_power_good),
        .rail_on_q           (rail_on_q),
        .switch_b2_on_q      (switch_b2_on_q),
        .aux_ldo1_on_q       (aux_ldo1_on_q),
        .pin_out_q           (pin_out_q),
        .pin_oe_q            (pin_oe_q)
    );
    rfo_host i_host (
        .clk   (clk),
        .wr_en (wr_en),
        .rd_en (rd_en),
        .addr  (addr),
        .wdata (wdata)
    );
    always #50 clk = ~clk;
    always @(posedge clk)
        if (++cyc == 500)
            results();
    task automatic chk(input logic [7:0] got, exp);
        tests_run++;
        n_fail += int'(got !== exp);
        if (got !== exp)
            $display("FAIL %0t got %h want %h", $time, got, exp);
    endtask
    task automatic results;
        // A hang counts as one mismatch
        n_fail += int'(cyc >= 500);
        $display("fails %0d checks %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_reg;
        i_host.go(1'h1, 8'ha1, 8'h5a);
        i_host.go(1'h0, 8'ha1, 8'h00);
        chk(rdata_q, 8'h5a);
        chk({7'h0, rvalid_q}, 8'h01);
        i_host.go(1'h1, 8'ha2, 8'hff);
        i_host.go(1'h0, 8'ha2, 8'h00);
        chk(rdata_q, 8'h00);
        // Write to the other address must have left the register alone
        i_host.go(1'h0, 8'ha1, 8'h00);
        chk(rdata_q, 8'h5a);
    endtask
    task automatic t_out;
        i_host.go(1'h1, 8'ha1, 8'haf);
        repeat (3) @(posedge clk) #1;
        chk({pin_out_q, pin_oe_q}, 8'hb4);
        chk({rail_on_q, 4'h0}, 8'hf0);
        chk({6'h0, switch_b2_on_q, aux_ldo1_on_q}, 8'h02);
        {rail_disable_n, ctl_seq_enable} = 8'h53;
        i_host.go(1'h1, 8'ha1, 8'h00);
        repeat (4) @(posedge clk) #1;
        chk({4'h0, rail_on_q}, 8'h01);
    endtask
    // Other strap, power-good low, every pin actively driven
    task automatic t_route;
        shared_is_switch_b2 = 1'h0;
        pin_power_good = 4'h0;
        {rail_disable_n, ctl_seq_enable} = 8'hf0;
        i_host.go(1'h1, 8'ha1, 8'h54);
        repeat (3) @(posedge clk) #1;
        chk({pin_out_q, pin_oe_q}, 8'h4f);
        chk({rail_on_q, 4'h0}, 8'h40);
        chk({6'h0, switch_b2_on_q, aux_ldo1_on_q}, 8'h01);
        i_host.go(1'h0, 8'ha1, 8'h00);
        chk(rdata_q, 8'h54);
    endtask
    initial
    begin
        repeat (12) @(posedge clk) #1;
        nrst = 1'h1;
        t_reg();
        t_out();
        t_route();
        results();
    end
endmodule // rfo_rail_force_on_tb
`default_nettype wire
